// File: rtl/clock_output_format_config.sv
// Function
// - bits 5:3 of the low pair register set output two's format.
// - bits 2:0 of the low pair register set output one's format.
// - bits 5:3 of the high pair register set output four's format.
// - bits 2:0 of the high pair register set output three's format.
// - the high pair resets to 2C and its bits 7:6 read as zero.
// - a cmos output takes its strength from the cmos drive field.
`timescale 1ns/1ns
module clock_output_format_config (
   input  wire logic                          clock,
   input  wire logic                          rst_n,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   input  wire logic [7:0]                    reg_addr,
   input  wire logic [7:0]                    reg_wdata,
   output      logic [7:0]                    reg_rdata,
   output      logic                          reg_rvalid,
   input  wire logic [2:0]                    out_five_format_field,
   input  wire logic                          supply_is_3v3,
   output      clock_format_pkg::buf_state_t  clock_output_one,
   output      clock_format_pkg::buf_state_t  clock_output_two,
   output      clock_format_pkg::buf_state_t  clock_output_three,
   output      clock_format_pkg::buf_state_t  clock_output_four,
   output      logic [2:0]                    enabled_count,
   output      logic [2:0]                    high_power_count,
   output      logic                          power_limit_violation
);

   // ==========================================================
   // register storage
   logic [7:0] lo_pair;
   logic [7:0] hi_pair;
   logic [2:0] out_one_format_field;
   logic [2:0] out_two_format_field;
   logic [2:0] out_three_format_field;
   logic [2:0] out_four_format_field;
   logic [1:0] cmos_drive_strength;

   assign out_one_format_field   =
      lo_pair[clock_format_pkg::FIELD_LOW_LSB +: 3];
   assign out_two_format_field   =
      lo_pair[clock_format_pkg::FIELD_HIGH_LSB +: 3];
   assign out_three_format_field =
      hi_pair[clock_format_pkg::FIELD_LOW_LSB +: 3];
   assign out_four_format_field  =
      hi_pair[clock_format_pkg::FIELD_HIGH_LSB +: 3];
   assign cmos_drive_strength    = lo_pair[clock_format_pkg::DRIVE_LSB +: 2];

   // low pair write: drive field and outputs one and two
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         lo_pair <= clock_format_pkg::RESET_LO_PAIR;
      end else if (reg_wr && reg_addr == clock_format_pkg::OFS_LO_PAIR) begin
         lo_pair <= reg_wdata;
      end
   end

   // high pair write: reserved top bits stay zero
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         hi_pair <= clock_format_pkg::RESET_HI_PAIR;
      end else if (reg_wr && reg_addr == clock_format_pkg::OFS_HI_PAIR) begin
         hi_pair <= reg_wdata &
                    ~clock_format_pkg::HI_RESERVED_MASK;
      end
   end

   // ==========================================================
   // read port: one cycle latency, unmapped reads give zero
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (!reg_rd) begin
            reg_rdata <= 8'h00;
         end else if (reg_addr == clock_format_pkg::OFS_LO_PAIR) begin
            reg_rdata <= lo_pair;
         end else if (reg_addr == clock_format_pkg::OFS_HI_PAIR) begin
            reg_rdata <= hi_pair;
         end else begin
            reg_rdata <= 8'h00;
         end
      end
   end

   // ==========================================================
   // per-output buffer state
   format_decode #(
      .RESET_CODE  (clock_format_pkg::RESET_LO_PAIR[2:0]),
      .RESET_DRIVE (clock_format_pkg::RESET_LO_PAIR[7:6])
   ) u_out_one (
      .clock (clock),
      .rst_n (rst_n),
      .code  (out_one_format_field),
      .drive (cmos_drive_strength),
      .state (clock_output_one)
   );

   format_decode #(
      .RESET_CODE  (clock_format_pkg::RESET_LO_PAIR[5:3]),
      .RESET_DRIVE (clock_format_pkg::RESET_LO_PAIR[7:6])
   ) u_out_two (
      .clock (clock),
      .rst_n (rst_n),
      .code  (out_two_format_field),
      .drive (cmos_drive_strength),
      .state (clock_output_two)
   );

   format_decode #(
      // reset code of this field is reserved; buffer starts low swing
      .RESET_CODE  (clock_format_pkg::CODE_LVDS_LOW),
      .RESET_DRIVE (clock_format_pkg::RESET_LO_PAIR[7:6])
   ) u_out_three (
      .clock (clock),
      .rst_n (rst_n),
      .code  (out_three_format_field),
      .drive (cmos_drive_strength),
      .state (clock_output_three)
   );

   format_decode #(
      .RESET_CODE  (clock_format_pkg::RESET_HI_PAIR[5:3]),
      .RESET_DRIVE (clock_format_pkg::RESET_LO_PAIR[7:6])
   ) u_out_four (
      .clock (clock),
      .rst_n (rst_n),
      .code  (out_four_format_field),
      .drive (cmos_drive_strength),
      .state (clock_output_four)
   );

   // ==========================================================
   // power budget summary over all five outputs
   function automatic logic is_on(input clock_format_pkg::buf_mode_t m);
      is_on = (m != clock_format_pkg::BUF_OFF);
   endfunction : is_on

   function automatic logic is_hot(input clock_format_pkg::buf_mode_t m);
      is_hot = (m == clock_format_pkg::BUF_LVPECL) ||
               (m == clock_format_pkg::BUF_CMOS);
   endfunction : is_hot

   logic       five_on;
   logic       five_hot;
   logic [2:0] next_enabled;
   logic [2:0] next_hot;

   // fifth output is judged by its raw code
   assign five_on  = (out_five_format_field != clock_format_pkg::CODE_DISABLE)
                  && (out_five_format_field != clock_format_pkg::CODE_RSVD_A)
                  && (out_five_format_field != clock_format_pkg::CODE_RSVD_B);
   assign five_hot = (out_five_format_field == clock_format_pkg::CODE_LVPECL) ||
                     (out_five_format_field == clock_format_pkg::CODE_CMOS);

   always_comb begin
      next_enabled = {2'h0, five_on};
      next_hot     = {2'h0, five_hot};
      next_enabled = next_enabled + {2'h0, is_on(clock_output_one.mode)};
      next_enabled = next_enabled + {2'h0, is_on(clock_output_two.mode)};
      next_enabled = next_enabled + {2'h0, is_on(clock_output_three.mode)};
      next_enabled = next_enabled + {2'h0, is_on(clock_output_four.mode)};
      next_hot     = next_hot + {2'h0, is_hot(clock_output_one.mode)};
      next_hot     = next_hot + {2'h0, is_hot(clock_output_two.mode)};
      next_hot     = next_hot + {2'h0, is_hot(clock_output_three.mode)};
      next_hot     = next_hot + {2'h0, is_hot(clock_output_four.mode)};
   end

   // registered counts and the flag for the host to check
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         enabled_count         <= 3'h0;
         high_power_count      <= 3'h0;
         power_limit_violation <= 1'b0;
      end else begin
         enabled_count         <= next_enabled;
         high_power_count      <= next_hot;
         power_limit_violation <= supply_is_3v3 &&
            (next_enabled == clock_format_pkg::ALL_FIVE) &&
            (next_hot >= clock_format_pkg::FOUR_HIGH);
      end
   end

   // ==========================================================
   // assertions
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_lo_write_store: assert property (
      reg_wr && reg_addr == clock_format_pkg::OFS_LO_PAIR
      |=> lo_pair == $past(reg_wdata))
      else $error("low pair did not take write");

   a_hi_top_zero: assert property (
      hi_pair[7:6] == 2'h0 and (reg_rvalid && $past(reg_rd) &&
      $past(reg_addr) == clock_format_pkg::OFS_HI_PAIR
      |-> reg_rdata[7:6] == 2'h0))
      else $error("high pair reserved bits not zero");

   a_hi_reset_val: assert property (
      $past(!rst_n) |-> hi_pair == clock_format_pkg::RESET_HI_PAIR)
      else $error("high pair reset value wrong");

   a_out_two_cmos: assert property (
      ##1 out_two_format_field == clock_format_pkg::CODE_CMOS
      |=> clock_output_two.mode == clock_format_pkg::BUF_CMOS &&
          clock_output_two.drive == $past(cmos_drive_strength))
      else $error("output two cmos state wrong");

   a_out_one_pecl: assert property (
      ##1 out_one_format_field == clock_format_pkg::CODE_LVPECL
      |=> clock_output_one.mode == clock_format_pkg::BUF_LVPECL &&
          clock_output_one.drive == 2'h0)
      else $error("output one lvpecl state wrong");

   a_out_four_hold: assert property (
      ##1 (out_four_format_field == clock_format_pkg::CODE_RSVD_A ||
       out_four_format_field == clock_format_pkg::CODE_RSVD_B)
      |=> $stable(clock_output_four))
      else $error("reserved code changed output four");

   a_out_three_cml: assert property (
      ##1 out_three_format_field == clock_format_pkg::CODE_CML
      |=> clock_output_three.mode == clock_format_pkg::BUF_CML)
      else $error("output three cml state wrong");

   a_drive_write_path: assert property (
      reg_wr && reg_addr == clock_format_pkg::OFS_LO_PAIR &&
      reg_wdata == {2'h1, clock_format_pkg::CODE_CMOS, 3'h1}
      ##1 !(reg_wr && reg_addr == clock_format_pkg::OFS_LO_PAIR)
      |=> clock_output_two.drive == 2'h1 &&
          clock_output_one.mode == clock_format_pkg::BUF_OFF)
      else $error("cmos drive not applied");

   a_power_flag: assert property (
      ##1 supply_is_3v3 && next_enabled == 3'h5 && next_hot == 3'h4
      |=> power_limit_violation && high_power_count == 3'h4)
      else $error("power limit flag missed");

   c_cmos_select: cover property (
      clock_output_one.mode == clock_format_pkg::BUF_CMOS);
   c_reserved_write: cover property (
      reg_wr && reg_addr == clock_format_pkg::OFS_HI_PAIR &&
      reg_wdata[2:0] == clock_format_pkg::CODE_RSVD_B);
   c_violation: cover property (power_limit_violation);
   c_hi_read: cover property (
      reg_rd && reg_addr == clock_format_pkg::OFS_HI_PAIR);

endmodule : clock_output_format_config

// File: rtl/clock_format_pkg.sv
package clock_format_pkg;

   // ==========================================================
   // register map
   localparam logic [7:0] OFS_LO_PAIR       = 8'h05;
   localparam logic [7:0] OFS_HI_PAIR       = 8'h06;
   localparam logic [7:0] RESET_LO_PAIR     = 8'hED;
   localparam logic [7:0] RESET_HI_PAIR     = 8'h2C;
   localparam logic [7:0] HI_RESERVED_MASK  = 8'hC0;
   localparam int         FIELD_LOW_LSB     = 0;
   localparam int         FIELD_HIGH_LSB    = 3;
   localparam int         DRIVE_LSB         = 6;
   localparam int         OUTPUT_COUNT      = 4;
   localparam logic [2:0] HIGH_POWER_LIMIT  = 3'h3;
   localparam logic [2:0] ALL_FIVE          = 3'h5;
   localparam logic [2:0] FOUR_HIGH         = 3'h4;

   // ==========================================================
   // format codes
   localparam logic [2:0] CODE_RSVD_A   = 3'h0;
   localparam logic [2:0] CODE_DISABLE  = 3'h1;
   localparam logic [2:0] CODE_CMOS     = 3'h2;
   localparam logic [2:0] CODE_LVDS_LOW = 3'h3;
   localparam logic [2:0] CODE_RSVD_B   = 3'h4;
   localparam logic [2:0] CODE_LVPECL   = 3'h5;
   localparam logic [2:0] CODE_CML      = 3'h6;
   localparam logic [2:0] CODE_LVDS     = 3'h7;

   // ==========================================================
   // buffer state carried to each output buffer
   typedef enum logic [2:0] {
      BUF_OFF,
      BUF_CMOS,
      BUF_LVDS_LOW,
      BUF_LVPECL,
      BUF_CML,
      BUF_LVDS
   } buf_mode_t;

   typedef struct packed {
      buf_mode_t  mode;
      logic [1:0] drive;    // cmos drive strength, zero otherwise
   } buf_state_t;

   localparam buf_state_t RESET_BUF = '{mode: BUF_OFF, drive: 2'h0};

endpackage : clock_format_pkg

// File: rtl/format_decode.sv
`timescale 1ns/1ns
module format_decode #(
   parameter logic [2:0] RESET_CODE  = 3'h1,
   parameter logic [1:0] RESET_DRIVE = 2'h0
) (
   input  wire logic                          clock,
   input  wire logic                          rst_n,
   input  wire logic [2:0]                    code,
   input  wire logic [1:0]                    drive,
   output      clock_format_pkg::buf_state_t  state
);

   // ==========================================================
   // code to mode; reserved codes report not valid
   function automatic logic decode_valid(input logic [2:0] c);
      decode_valid = (c != clock_format_pkg::CODE_RSVD_A) &&
                     (c != clock_format_pkg::CODE_RSVD_B);
   endfunction : decode_valid

   function automatic clock_format_pkg::buf_mode_t
         decode_mode(input logic [2:0] c);
      case (c)
         clock_format_pkg::CODE_CMOS:     decode_mode =
            clock_format_pkg::BUF_CMOS;
         clock_format_pkg::CODE_LVDS_LOW: decode_mode =
            clock_format_pkg::BUF_LVDS_LOW;
         clock_format_pkg::CODE_LVPECL:   decode_mode =
            clock_format_pkg::BUF_LVPECL;
         clock_format_pkg::CODE_CML:      decode_mode =
            clock_format_pkg::BUF_CML;
         clock_format_pkg::CODE_LVDS:     decode_mode =
            clock_format_pkg::BUF_LVDS;
         default:                         decode_mode =
            clock_format_pkg::BUF_OFF;
      endcase
   endfunction : decode_mode

   clock_format_pkg::buf_mode_t next_mode;

   assign next_mode = decode_mode(code);

   // buffer state; reserved codes leave it unchanged
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state.mode  <= decode_mode(RESET_CODE);
         state.drive <= (decode_mode(RESET_CODE) ==
                         clock_format_pkg::BUF_CMOS) ? RESET_DRIVE : 2'h0;
      end else if (decode_valid(code)) begin
         state.mode  <= next_mode;
         state.drive <= (next_mode == clock_format_pkg::BUF_CMOS) ?
                        drive : 2'h0;
      end
   end

endmodule : format_decode

// File: tb/format_host.sv
`timescale 1ns/1ns
module format_host (
   input  wire logic       clock,
   output      logic       reg_wr,
   output      logic       reg_rd,
   output      logic [7:0] reg_addr,
   output      logic [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_rvalid
);
   // ==========================================================
   // bus idle at time zero
   initial begin
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 8'hFF;
      reg_wdata = 8'h00;
   end

   // one write; the caller keeps the power limits and, with no bypass
   // here, may pick cmos freely (a scenario may break the limits)
   task automatic write_reg(input logic [7:0] addr,
                            input logic [7:0] data);
      reg_wr    = 1'b1;
      reg_addr  = addr;
      reg_wdata = data;
      @(posedge clock);
      #1;
      reg_wr    = 1'b0;
      reg_addr  = ~addr;   // released lines lose their last value
      reg_wdata = ~data;
      // idle edge so a following call never re-raises at once
      @(posedge clock);
      #1;
   endtask : write_reg

   // one read; data and valid are taken at the answering edge
   task automatic read_reg(input  logic [7:0] addr,
                           output logic [7:0] data,
                           output logic       valid);
      reg_rd   = 1'b1;
      reg_addr = addr;
      @(posedge clock);
      #1;
      data     = reg_rdata;
      valid    = reg_rvalid;
      reg_rd   = 1'b0;
      reg_addr = ~addr;
      // idle edge so a following call never re-raises at once
      @(posedge clock);
      #1;
   endtask : read_reg
endmodule : format_host

// File: tb/clock_output_format_config_bench.sv
`timescale 1ns/1ns
module clock_output_format_config_bench;
   logic                         clock;
   logic                         rst_n;
   logic                         reg_wr;
   logic                         reg_rd;
   logic [7:0]                   reg_addr;
   logic [7:0]                   reg_wdata;
   logic [7:0]                   reg_rdata;
   logic                         reg_rvalid;
   logic [2:0]                   five;
   logic                         supply_is_3v3;
   clock_format_pkg::buf_state_t st [4];
   logic [2:0]                   enabled_count;
   logic [2:0]                   high_power_count;
   logic                         power_limit_violation;
   logic [2:0]                   exp_mode [4];
   logic [2:0]                   cd [4];
   logic [7:0]                   rd;
   logic                         rv;
   int                           miscompares;
   int                           compares;

   // ==========================================================
   // design, host model and clock
   clock_output_format_config u_dut (
      .clock(clock), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .out_five_format_field(five),
      .supply_is_3v3(supply_is_3v3), .clock_output_one(st[0]),
      .clock_output_two(st[1]), .clock_output_three(st[2]),
      .clock_output_four(st[3]), .enabled_count(enabled_count),
      .high_power_count(high_power_count),
      .power_limit_violation(power_limit_violation));
   format_host u_host (
      .clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // ==========================================================
   // compare, verdict, code to buffer mode
   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic give_verdict;
      if (miscompares == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : give_verdict

   function automatic logic [2:0] to_mode(input logic [2:0] c,
                                          input logic [2:0] old);
      case (c)
         3'h1:    return 3'h0;
         3'h2:    return 3'h1;
         3'h3:    return 3'h2;
         3'h5:    return 3'h3;
         3'h6:    return 3'h4;
         3'h7:    return 3'h5;
         default: return old;   // reserved codes keep the buffer
      endcase
   endfunction : to_mode

   // reads both pairs and compares all four buffers with drive dr
   task automatic check_all(input logic [7:0] lo, input logic [7:0] hi,
                            input logic [1:0] dr);
      u_host.read_reg(8'h05, rd, rv);
      check("lo_pair", rd, lo);
      check("lo_valid", {7'h0, rv}, 8'h01);
      u_host.read_reg(8'h06, rd, rv);
      check("hi_pair", rd, hi);
      check("hi_valid", {7'h0, rv}, 8'h01);
      for (int i = 0; i < 4; i++)
         check("output_state", {3'h0, st[i]}, {3'h0, exp_mode[i],
               (exp_mode[i] == 3'h1) ? dr : 2'h0});
   endtask : check_all

   // watchdog
   initial begin
      #100000;
      miscompares++;
      give_verdict();
   end

   // ==========================================================
   // reset, every code in every field, unmapped read, power flag
   initial begin
      miscompares   = 0;
      compares      = 0;
      rst_n         = 1'b0;
      five          = 3'h1;
      supply_is_3v3 = 1'b1;
      repeat (5) @(posedge clock);
      #1;
      rst_n = 1'b1;
      repeat (2) @(posedge clock);
      #1;
      exp_mode = '{3'h3, 3'h3, 3'h2, 3'h3};
      check_all(8'hED, 8'h2C, 2'h3);
      for (int c = 0; c < 8; c++) begin
         for (int i = 0; i < 4; i++) begin
            cd[i] = 3'(c + 3 * i);
            exp_mode[i] = to_mode(cd[i], exp_mode[i]);
         end
         u_host.write_reg(8'h05, {2'(c), cd[1], cd[0]});
         u_host.write_reg(8'h06, {2'h3, cd[3], cd[2]});
         check_all({2'(c), cd[1], cd[0]}, {2'h0, cd[3], cd[2]}, 2'(c));
      end
      u_host.write_reg(8'h07, 8'h00);
      u_host.read_reg(8'h07, rd, rv);
      check("unmapped", rd, 8'h00);
      check("unmapped_valid", {7'h0, rv}, 8'h01);
      // cmos on output two with drive 1, output one off
      u_host.write_reg(8'h05, 8'h51);
      exp_mode[0] = 3'h0;
      exp_mode[1] = 3'h1;
      check_all(8'h51, {2'h0, cd[3], cd[2]}, 2'h1);
      // five outputs on with four hot at 3.3 V breaks the limit
      five = 3'h7;
      u_host.write_reg(8'h05, 8'h6D);
      u_host.write_reg(8'h06, 8'h2D);
      repeat (4) @(posedge clock);
      #1;
      check("enabled_count", {5'h0, enabled_count}, 8'h05);
      check("high_power", {5'h0, high_power_count}, 8'h04);
      check("violation", {7'h0, power_limit_violation}, 8'h01);
      // the limits apply at 3.3 V only
      supply_is_3v3 = 1'b0;
      repeat (2) @(posedge clock);
      #1;
      check("violation", {7'h0, power_limit_violation}, 8'h00);
      supply_is_3v3 = 1'b1;
      // three hot is within the limit
      u_host.write_reg(8'h06, 8'h2E);
      repeat (4) @(posedge clock);
      #1;
      check("violation", {7'h0, power_limit_violation}, 8'h00);
      give_verdict();
   end
endmodule : clock_output_format_config_bench
